// *** inc/cmf_consts.svh ***
// Purpose: constants of the clock mux and gated fanout
// Assumes: one core clock, all pins but the asynchronous I_RST_N sampled on it
// Notes:   reset values of the state fields
`ifndef CMF_CONSTS_SVH
`define CMF_CONSTS_SVH

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define CMF_FANOUT_N   4
`define CMF_SYNC_RST   2'h0
`define CMF_GATE_RST   1'h0
`define CMF_TRUE_RST   4'h0
`define CMF_COMP_RST   4'hf

`endif

// *** inc/cmf_pkg.sv ***
// Purpose: types of the clock mux and gated fanout
// Assumes: constants come from cmf_consts.svh
// Notes:   whole module state is one packed struct
`include "cmf_consts.svh"

package cmf_pkg;

  // ----------------------------------------
  // module state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]                  sync_pri;
    logic [1:0]                  sync_alt;
    logic [1:0]                  sync_sel;
    logic [1:0]                  sync_en;
    logic                        prev_clk;
    logic                        seen_rise;
    logic                        gate_on;
    logic [`CMF_FANOUT_N-1:0]    out_true;
    logic [`CMF_FANOUT_N-1:0]    out_comp;
  } cmf_state_t;

endpackage : cmf_pkg

// *** rtl/cmf_fanout.sv ***
// Purpose: 2:1 reference clock mux gated onto four differential output pairs
// Assumes: reference clocks and controls are pins sampled on I_CORE_CLK
// Notes:   unconnected-pin defaults come from board pulls on the control pins
`timescale 1ns/1ps
`include "cmf_consts.svh"

//Behaviour
// - source choice low routes primary reference, high routes alternate reference
// - unconnected source choice reads low, so primary reference is selected
// - gate request high enables outputs; unconnected gate request reads enabled
// - while disabled, true legs low and complement legs high
// - while enabled, true legs follow selected clock, complements its inverse
// - enable state changes only while selected clock and outputs are low
// - gate request captured on falling edge of selected clock
// - new gate state takes effect after one rising then one falling edge
// - four identical differential pairs share one common enable
module cmf_fanout
  import cmf_pkg::*;
(
  // clock and reset
  input  wire logic I_CORE_CLK,
  input  wire logic I_RST_N,
  // reference clocks and controls
  input  wire logic I_REF_PRI,
  input  wire logic I_REF_ALT,
  input  wire logic I_SRC_SEL,
  input  wire logic I_GATE_REQ,
  // differential fanout
  output logic      O_FANOUT_OUT_0,
  output logic      O_FANOUT_OUT_0_N,
  output logic      O_FANOUT_OUT_1,
  output logic      O_FANOUT_OUT_1_N,
  output logic      O_FANOUT_OUT_2,
  output logic      O_FANOUT_OUT_2_N,
  output logic      O_FANOUT_OUT_3,
  output logic      O_FANOUT_OUT_3_N
);

  cmf_state_t st;
  cmf_state_t next_st;
  logic       sel_clk;
  logic       rise;
  logic       fall;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // level change of one sampled line, in the wanted direction
  function automatic logic cmf_edge(input logic prev, input logic cur, input logic up);
    cmf_edge = up ? (~prev & cur) : (prev & ~cur);
  endfunction : cmf_edge

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st          = st;
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    next_st.sync_pri = {st.sync_pri[0], I_REF_PRI};
    next_st.sync_alt = {st.sync_alt[0], I_REF_ALT};
    next_st.sync_sel = {st.sync_sel[0], I_SRC_SEL};
    next_st.sync_en  = {st.sync_en[0], I_GATE_REQ};
    // ----------------------------------------
    // source choice and clock edges
    // ----------------------------------------
    // low picks primary; open pin pulled low
    sel_clk          = st.sync_sel[1] ? st.sync_alt[1] : st.sync_pri[1];
    rise             = cmf_edge(st.prev_clk, sel_clk, 1'b1);
    fall             = cmf_edge(st.prev_clk, sel_clk, 1'b0);
    next_st.prev_clk = sel_clk;
    // ----------------------------------------
    // gate capture
    // ----------------------------------------
    // a rising edge must be seen before the capturing fall
    if (st.sync_en[1] == st.gate_on) begin
      next_st.seen_rise = 1'b0;
    end else if (rise) begin
      next_st.seen_rise = 1'b1;
    end
    // capture on falling edge, outputs go low on the same core edge
    if (fall && st.seen_rise) begin
      next_st.gate_on   = st.sync_en[1];
      next_st.seen_rise = 1'b0;
    end
    // ----------------------------------------
    // fanout
    // ----------------------------------------
    // common gate on all pairs
    next_st.out_true = {`CMF_FANOUT_N{next_st.gate_on & sel_clk}};
    next_st.out_comp = ~next_st.out_true;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st.sync_pri  <= `CMF_SYNC_RST;
      st.sync_alt  <= `CMF_SYNC_RST;
      st.sync_sel  <= `CMF_SYNC_RST;
      st.sync_en   <= `CMF_SYNC_RST;
      st.prev_clk  <= 1'h0;
      st.seen_rise <= 1'h0;
      st.gate_on   <= `CMF_GATE_RST;
      st.out_true  <= `CMF_TRUE_RST;
      st.out_comp  <= `CMF_COMP_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign O_FANOUT_OUT_0   = st.out_true[0];
  assign O_FANOUT_OUT_0_N = st.out_comp[0];
  assign O_FANOUT_OUT_1   = st.out_true[1];
  assign O_FANOUT_OUT_1_N = st.out_comp[1];
  assign O_FANOUT_OUT_2   = st.out_true[2];
  assign O_FANOUT_OUT_2_N = st.out_comp[2];
  assign O_FANOUT_OUT_3   = st.out_true[3];
  assign O_FANOUT_OUT_3_N = st.out_comp[3];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_src_select: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    1'b1 |=> st.prev_clk == ($past(st.sync_sel[1]) ? $past(st.sync_alt[1]) : $past(st.sync_pri[1])))
    else $error("selected clock does not match source choice");

  a_gate_follows_req: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    $changed(st.gate_on) |-> st.gate_on == $past(st.sync_en[1]))
    else $error("gate state differs from request");

  a_disabled_legs: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    !st.gate_on |-> (st.out_true == 4'h0) && (st.out_comp == 4'hf))
    else $error("disabled outputs not true low complement high");

  a_enabled_follow: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    st.gate_on |-> st.out_true == {4{st.prev_clk}})
    else $error("enabled outputs do not follow selected clock");

  a_change_low: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    $changed(st.gate_on) |-> !st.prev_clk && (st.out_true == 4'h0) && ($past(st.out_true) == {4{$past(st.gate_on)}}))
    else $error("gate changed while outputs high");

  a_gate_on_fall: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    $changed(st.gate_on) |-> $past(st.prev_clk))
    else $error("gate changed without falling edge");

  a_rise_first: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    $changed(st.gate_on) |-> $past(st.seen_rise))
    else $error("gate changed without prior rising edge");

  a_pairs_equal: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (st.out_comp == ~st.out_true) && (st.out_true == 4'h0 || st.out_true == 4'hf))
    else $error("fanout pairs differ");

  // ----------------------------------------
  // checks on gate capture
  // ----------------------------------------
  a_hold_off: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    !st.gate_on && !st.sync_en[1]
    |=> !st.gate_on)
    else $error("outputs enabled without gate request");

  a_hold_on: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    st.gate_on && st.sync_en[1]
    |=> st.gate_on)
    else $error("outputs disabled while gate request high");

  a_capture_fall: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    fall && st.seen_rise
    |=> st.gate_on == $past(st.sync_en[1]))
    else $error("gate request not captured at falling edge");

  a_rise_arms: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    rise && (st.sync_en[1] != st.gate_on)
    |=> st.seen_rise)
    else $error("rising edge did not arm gate capture");

  a_revert_drop: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    st.sync_en[1] == st.gate_on
    |=> !st.seen_rise)
    else $error("capture armed without pending request");

  // ----------------------------------------
  // checks on fanout legs
  // ----------------------------------------
  a_rise_with_clk: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    $rose(st.out_true[0])
    |-> $rose(st.prev_clk))
    else $error("output rose without selected clock rising");

  a_fall_with_clk: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    $fell(st.out_true[0])
    |-> $fell(st.prev_clk))
    else $error("output fell without selected clock falling");

  a_low_clk_low: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    !st.prev_clk
    |-> st.out_true == 4'h0)
    else $error("outputs high while selected clock low");

  a_comp_follow: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    st.gate_on
    |-> st.out_comp == {4{!st.prev_clk}})
    else $error("complement legs do not follow inverse clock");

  a_ports_off: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    !st.gate_on
    |-> !(O_FANOUT_OUT_0 || O_FANOUT_OUT_1 || O_FANOUT_OUT_2 || O_FANOUT_OUT_3))
    else $error("true leg high while outputs disabled");

  a_ports_pairs: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (O_FANOUT_OUT_0_N == !O_FANOUT_OUT_0) && (O_FANOUT_OUT_1_N == !O_FANOUT_OUT_1)
    && (O_FANOUT_OUT_2_N == !O_FANOUT_OUT_2) && (O_FANOUT_OUT_3_N == !O_FANOUT_OUT_3))
    else $error("complement leg not inverse of true leg");

  a_ports_equal: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (O_FANOUT_OUT_1 == O_FANOUT_OUT_0) && (O_FANOUT_OUT_2 == O_FANOUT_OUT_0)
    && (O_FANOUT_OUT_3 == O_FANOUT_OUT_0))
    else $error("true legs differ between pairs");

endmodule : cmf_fanout

// *** bench/cmf_ref_src.sv ***
// Purpose: reference clock source model
// Assumes: toggles on core clock edges
// Notes:   half period in core cycles
`timescale 1ns/1ps
module cmf_ref_src #(
  parameter int HALF = 8
) (
  // clock
  input  wire logic i_clk,
  // reference
  output logic      o_ref
);
  int cnt = 0;
  initial o_ref = 1'b0;
  always @(posedge i_clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) o_ref <= ~o_ref;
  end
endmodule : cmf_ref_src

// *** bench/cmf_fanout_test.sv ***
// Purpose: self-checking bench of the clock mux and gated fanout
// Assumes: outputs trail the selected pin by 3 core cycles
// Notes:   board pull levels driven as plain values
`timescale 1ns/1ps
module cmf_fanout_test;
  import cmf_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       sel;
  logic       gate;
  logic       pri;
  logic       alt;
  logic [2:0] dly = 3'h0;
  logic [7:0] got;
  int         num_errors = 0;
  int         compares = 0;
  localparam int HALF_PRI = 8;
  localparam int HALF_ALT = 5;
  // ----------------------
  // clock, sources, design
  // ----------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  cmf_ref_src #(.HALF(HALF_PRI)) u_pri (.i_clk(clk), .o_ref(pri));
  cmf_ref_src #(.HALF(HALF_ALT)) u_alt (.i_clk(clk), .o_ref(alt));
  cmf_fanout DUT (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REF_PRI(pri), .I_REF_ALT(alt),
    .I_SRC_SEL(sel), .I_GATE_REQ(gate), .O_FANOUT_OUT_0(got[1]), .O_FANOUT_OUT_0_N(got[0]),
    .O_FANOUT_OUT_1(got[3]), .O_FANOUT_OUT_1_N(got[2]), .O_FANOUT_OUT_2(got[5]),
    .O_FANOUT_OUT_2_N(got[4]), .O_FANOUT_OUT_3(got[7]), .O_FANOUT_OUT_3_N(got[6]));
  always @(posedge clk) dly <= {dly[1:0], sel ? alt : pri};
  // ----------------------
  // tasks
  // ----------------------
  task automatic chk(input logic [7:0] exp, input logic [7:0] act);
    compares++;
    if (act !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask : chk
  task automatic watch(input int n);
    int run;
    run = -1;
    repeat (n) begin
      @(negedge clk);
      if (got[1]) begin
        if (run >= 0) run++;
      end else begin
        if (run > 0) chk(8'(sel ? HALF_ALT : HALF_PRI), 8'(run));
        run = 0;
      end
    end
  endtask : watch
  task automatic t_off(input logic s);
    @(posedge clk) gate <= 1'b0;
    watch(60);
    @(posedge clk) sel <= s;
    repeat (10) @(posedge clk);
    repeat (20) begin
      @(negedge clk);
      chk(8'h55, got);
    end
  endtask : t_off
  task automatic t_on;
    @(posedge clk) gate <= 1'b1;
    repeat (4) begin
      @(negedge clk);
      chk(8'h55, got);
    end
    watch(56);
    repeat (30) begin
      @(negedge clk);
      chk({4{dly[2], ~dly[2]}}, got);
    end
  endtask : t_on
  task automatic t_rst;
    @(posedge clk) rst_n <= 1'b0;
    repeat (5) begin
      @(negedge clk);
      chk(8'h55, got);
    end
    @(posedge clk) rst_n <= 1'b1;
    repeat (2) begin
      @(negedge clk);
      chk(8'h55, got);
    end
    watch(60);
    repeat (10) begin
      @(negedge clk);
      chk({4{dly[2], ~dly[2]}}, got);
    end
  endtask : t_rst
  task automatic end_sim;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // ----------------------
  // sequence and watchdog
  // ----------------------
  initial begin
    rst_n = 1'b0;
    sel = 1'b0;
    gate = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_off(1'b0);
    t_on();
    t_off(1'b1);
    t_on();
    t_rst();
    t_off(1'b0);
    end_sim();
  end
  initial begin
    #160000;
    num_errors++;
    end_sim();
  end
endmodule : cmf_fanout_test
